// ===== hdl/rsc_ctrl.sv
// reset scope controller: detection flags, scoped clears, clock fallback
// Behaviour
// - por flag cleared only by pin reset
// - cold/warm flag initialised only by power-on
// - monitor 0 flag cleared by pin, power-on
// - independent watchdog flag/registers scoped clear
// - watchdog flag/registers scoped clear
// - monitor 1 flag scoped clear
// - monitor 1 registers; deep clears two only
// - monitor 2 flag/registers; deep clears two
// - deep flag kept on deep, software
// - software flag kept only on software
// - realtime clock never cleared
// - oscillators, pins, low power kept on deep
// - everything else cleared on every source
// - slow oscillator selected, others stopped after reset
// - common vector, three readable status registers
//
// The address map and the APB register port were left to the implementer.
`default_nettype none

module rsc_ctrl
    import rsc_pkg::*;
#(
    parameter logic [31:0] RESET_VECTOR = 32'h0000_0000
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          ce,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [AW-1:0] paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          src_pin_n,
    input  wire logic          src_por,
    input  wire logic          src_mon0,
    input  wire logic          src_independent_watchdog,
    input  wire logic          src_wdt,
    input  wire logic          src_mon1,
    input  wire logic          src_mon2,
    input  wire logic          src_deep,
    input  wire logic          src_sw,
    output logic               clr_independent_watchdog,
    output logic               clr_wdt,
    output logic               clr_mon1,
    output logic               clr_mon1_part,
    output logic               clr_mon2,
    output logic               clr_mon2_part,
    output logic               clr_rtc,
    output logic               clr_osc_pin_lp,
    output logic               clr_rest,
    output logic               fast_internal_osc_en,
    output logic               main_osc_en,
    output logic               pll_en,
    output logic [1:0]         sys_clk_sel,
    output logic               slow_internal_osc_sel,
    output logic               irq
);

    // ----------------------------------------
    // declarations and helpers
    // ----------------------------------------
    logic [NSRC-1:0] raw;
    logic [NSRC-1:0] lvl;
    logic [NSRC-1:0] ev;
    logic [NSRC-1:0] det;
    logic            cws;
    logic [NSRC-1:0] ist;
    logic [NSRC-1:0] imask;
    logic [CC_W-1:0] cctl;
    logic [NTGT-1:0] clr;
    logic            any_ev;
    logic            setup;
    logic            acc;
    logic            wr;
    logic            addr_ok;
    logic [31:0]     rd_word;

    function automatic logic hit(input logic [NSRC-1:0] e, input logic [NSRC-1:0] m);
        hit = |(e & m);
    endfunction : hit

    function automatic logic solo(input logic [NSRC-1:0] e, input int s);
        solo = (e == (NSRC'(1) << s));
    endfunction : solo

    // ----------------------------------------
    // source capture
    // ----------------------------------------
    // pin reset is active low; invert ahead of the synchroniser
    assign raw = {src_sw, src_deep, src_mon2, src_mon1, src_wdt,
                  src_independent_watchdog, src_mon0, src_por, ~src_pin_n};

    rsc_sync #(
        .W (NSRC)
    ) u_sync (
        .clk   (pclk),
        .rst_n (presetn),
        .ce    (ce),
        .d     (raw),
        .q     (lvl),
        .rise  (ev)
    );

    assign any_ev = |ev;

    // ----------------------------------------
    // scoped clear pulses
    // ----------------------------------------
    // one registered pulse on each target whose mask the reset event hits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clr <= '0;
        end else if (ce) begin
            for (int t = 0; t < NTGT; t++) begin
                clr[t] <= hit(ev, TGT_MASK[t]);
            end
        end
    end

    assign clr_independent_watchdog       = clr[T_INDEPENDENT_WATCHDOG];
    assign clr_wdt        = clr[T_WDT];
    assign clr_mon1       = clr[T_MON1];
    assign clr_mon1_part  = clr[T_MON1P];
    assign clr_mon2       = clr[T_MON2];
    assign clr_mon2_part  = clr[T_MON2P];
    assign clr_rtc        = clr[T_RTC];
    assign clr_osc_pin_lp = clr[T_OSC];
    assign clr_rest       = clr[T_REST];

    // ----------------------------------------
    // detection flags
    // ----------------------------------------
    // the own set is ored last so a shared event cannot lose it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            det <= '0;
        end else if (ce) begin
            for (int s = 1; s < NSRC; s++) begin
                det[s] <= ev[s] | (det[s] & ~hit(ev, FLG_MASK[s]));
            end
        end
    end

    // cold start reads 0; software marks warm by writing 1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cws <= 1'b0;
        end else if (ce) begin
            if (hit(ev, CWS_MASK)) begin
                cws <= 1'b0;
            end else if (wr && paddr == OFS_STAT2) begin
                cws <= pwdata[B2_CWS];
            end
        end
    end

    // ----------------------------------------
    // clock source control
    // ----------------------------------------
    // any reset event drops back to the slow oscillator, others off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cctl <= CCTL_RST;
        end else if (ce) begin
            if (any_ev) begin
                cctl <= CCTL_RST;
            end else if (wr && paddr == OFS_CCTL) begin
                cctl <= pwdata[CC_W-1:0];
            end
        end
    end

    assign fast_internal_osc_en  = cctl[CC_FAST];
    assign main_osc_en           = cctl[CC_MAIN];
    assign pll_en                = cctl[CC_PLL];
    assign sys_clk_sel           = cctl[CC_SEL+:2];
    assign slow_internal_osc_sel = (sys_clk_sel == SEL_SLOW);

    // ----------------------------------------
    // interrupt status and mask
    // ----------------------------------------
    // write one clears; a new event in the same cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ist <= '0;
        end else if (ce) begin
            if (wr && paddr == OFS_IST) begin
                ist <= ev | (ist & ~pwdata[NSRC-1:0]);
            end else begin
                ist <= ev | ist;
            end
        end
    end

    // mask survives reset events so the event itself can interrupt
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            imask <= IMSK_RST;
        end else if (ce && wr && paddr == OFS_IMSK) begin
            imask <= pwdata[NSRC-1:0];
        end
    end

    assign irq = |(ist & imask);

    // ----------------------------------------
    // apb slave
    // ----------------------------------------
    // no wait states; a low clock enable stretches the access instead
    assign setup   = psel && !penable;
    assign acc     = psel && penable;
    assign wr      = ce && acc && pwrite;
    assign pready  = ce;
    assign pslverr = acc && !addr_ok;

    // read decode; three status words expose the cause flags
    always_comb begin
        rd_word = '0;
        addr_ok = 1'b1;
        case (paddr)
            OFS_STAT0: begin
                rd_word[B0_POR]  = det[S_POR];
                rd_word[B0_MON0] = det[S_MON0];
                rd_word[B0_MON1] = det[S_MON1];
                rd_word[B0_MON2] = det[S_MON2];
                rd_word[B0_DEEP] = det[S_DEEP];
            end
            OFS_STAT1: begin
                rd_word[B1_SW]   = det[S_SW];
                rd_word[B1_WDT]  = det[S_WDT];
                rd_word[B1_INDEPENDENT_WATCHDOG] = det[S_INDEPENDENT_WATCHDOG];
            end
            OFS_STAT2: begin
                rd_word[B2_CWS] = cws;
            end
            OFS_IST: begin
                rd_word[NSRC-1:0] = ist;
            end
            OFS_IMSK: begin
                rd_word[NSRC-1:0] = imask;
            end
            OFS_CCTL: begin
                rd_word[CC_W-1:0] = cctl;
            end
            OFS_VEC: begin
                rd_word = RESET_VECTOR;
            end
            default: begin
                addr_ok = 1'b0;
            end
        endcase
    end

    // read data captured in setup, steady through the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
        end else if (ce && setup && !pwrite) begin
            prdata <= rd_word;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    por_flag_clr_a: assert property (ce && ev[S_PIN] && !ev[S_POR] |=> !det[S_POR])
        else $error("power-on flag not cleared by pin reset");
    por_flag_keep_a: assert property (ce && solo(ev, S_MON0) |=> $stable(det[S_POR]))
        else $error("power-on flag changed on monitor 0 reset");
    cws_keep_a: assert property (ce && !ev[S_POR] && !(wr && paddr == OFS_STAT2) |=> $stable(cws))
        else $error("cold/warm flag changed without power-on");
    mon0_flag_clr_a: assert property (ce && ev[S_PIN] && !ev[S_MON0] |=> !det[S_MON0])
        else $error("monitor 0 flag not cleared by pin reset");
    independent_watchdog_scope_a: assert property (ce && solo(ev, S_WDT) |=> !clr_independent_watchdog && $stable(det[S_INDEPENDENT_WATCHDOG]))
        else $error("independent watchdog touched by watchdog reset");
    wdt_scope_a: assert property (ce && solo(ev, S_INDEPENDENT_WATCHDOG) |=> clr_wdt && !clr_independent_watchdog && !det[S_WDT])
        else $error("watchdog scope wrong on independent watchdog reset");
    mon1_flag_keep_a: assert property (ce && solo(ev, S_SW) |=> $stable(det[S_MON1]) && !clr_mon1)
        else $error("monitor 1 flag changed on software reset");
    mon1_deep_a: assert property (ce && solo(ev, S_DEEP) |=> clr_mon1_part && !clr_mon1)
        else $error("monitor 1 partial clear wrong on deep reset");
    mon2_deep_a: assert property (ce && solo(ev, S_DEEP) |=> clr_mon2_part && !clr_mon2 && clr_independent_watchdog)
        else $error("monitor 2 partial clear wrong on deep reset");
    mon2_by_mon1_a: assert property (ce && solo(ev, S_MON1) |=> clr_mon2 && !det[S_MON2])
        else $error("monitor 2 not cleared by monitor 1 reset");
    deep_flag_a: assert property (ce && solo(ev, S_MON2) |=> !det[S_DEEP])
        else $error("deep standby flag not cleared");
    sw_flag_a: assert property (ce && solo(ev, S_DEEP) |=> !det[S_SW] ##1 det[S_DEEP] || !ce)
        else $error("software flag not cleared by deep reset");
    rtc_never_a: assert property (!clr_rtc)
        else $error("realtime clock clear asserted");
    osc_scope_a: assert property (ce && solo(ev, S_DEEP) |=> !clr_osc_pin_lp && clr_rest)
        else $error("oscillator group cleared by deep reset");
    rest_all_a: assert property (ce && any_ev |=> clr_rest && slow_internal_osc_sel && !pll_en)
        else $error("general clear or clock fallback missing");
    set_wins_a: assert property (ce && ev[S_PIN] && ev[S_POR] |=> det[S_POR] && ist[S_POR])
        else $error("own set lost to simultaneous clear");
    vec_read_a: assert property (ce && setup && !pwrite && paddr == OFS_VEC |=> prdata == RESET_VECTOR)
        else $error("reset vector read back wrong");

    pin_reset_c: cover property (ce && solo(ev, S_PIN) ##1 clr_rest);
    deep_reset_c: cover property (ce && solo(ev, S_DEEP) ##1 clr_mon1_part);
    sw_irq_c: cover property (ce && solo(ev, S_SW) ##1 irq);
    twin_reset_c: cover property (ce && ev[S_PIN] && ev[S_POR]);

endmodule : rsc_ctrl

`default_nettype wire

// ===== hdl/rsc_pkg.sv
// shared constants for the reset scope controller
`default_nettype none

package rsc_pkg;

    // ----------------------------------------
    // reset sources, bit index in event vectors
    // ----------------------------------------
    localparam int NSRC   = 9;
    localparam int S_PIN  = 0;
    localparam int S_POR  = 1;
    localparam int S_MON0 = 2;
    localparam int S_INDEPENDENT_WATCHDOG = 3;
    localparam int S_WDT  = 4;
    localparam int S_MON1 = 5;
    localparam int S_MON2 = 6;
    localparam int S_DEEP = 7;
    localparam int S_SW   = 8;

    // ----------------------------------------
    // clear targets and the sources that hit them
    // ----------------------------------------
    localparam int NTGT    = 9;
    localparam int T_INDEPENDENT_WATCHDOG  = 0;
    localparam int T_WDT   = 1;
    localparam int T_MON1  = 2;
    localparam int T_MON1P = 3;
    localparam int T_MON2  = 4;
    localparam int T_MON2P = 5;
    localparam int T_RTC   = 6;
    localparam int T_OSC   = 7;
    localparam int T_REST  = 8;

    // mask bit order: sw deep mon2 mon1 wdt independent_watchdog mon0 por pin
    localparam logic [NSRC-1:0] TGT_MASK [NTGT] = '{
        9'h087,  // watchdog-independent registers
        9'h08F,  // watchdog registers
        9'h01F,  // monitor 1 registers, full set
        9'h09F,  // monitor1_ctrl_b and monitor1_status
        9'h03F,  // monitor 2 registers, full set
        9'h0BF,  // monitor_ctrl_c and monitor2_status
        9'h000,  // realtime clock never cleared
        9'h17F,  // oscillators, pins, low power
        9'h1FF   // everything else
    };

    // detection flag clear masks, indexed by owning source
    localparam logic [NSRC-1:0] FLG_MASK [NSRC] = '{
        9'h000,  // pin reset has no flag
        9'h001,
        9'h003,
        9'h087,
        9'h08F,
        9'h01F,
        9'h03F,
        9'h07F,
        9'h0FF
    };
    localparam logic [NSRC-1:0] CWS_MASK = 9'h002;

    // ----------------------------------------
    // register map and fields
    // ----------------------------------------
    localparam int          AW        = 8;
    localparam logic [7:0]  OFS_STAT0 = 8'h00;
    localparam logic [7:0]  OFS_STAT1 = 8'h04;
    localparam logic [7:0]  OFS_STAT2 = 8'h08;
    localparam logic [7:0]  OFS_IST   = 8'h0C;
    localparam logic [7:0]  OFS_IMSK  = 8'h10;
    localparam logic [7:0]  OFS_CCTL  = 8'h14;
    localparam logic [7:0]  OFS_VEC   = 8'h18;
    localparam int          B0_POR    = 0;
    localparam int          B0_MON0   = 1;
    localparam int          B0_MON1   = 2;
    localparam int          B0_MON2   = 3;
    localparam int          B0_DEEP   = 4;
    localparam int          B1_SW     = 0;
    localparam int          B1_WDT    = 1;
    localparam int          B1_INDEPENDENT_WATCHDOG   = 2;
    localparam int          B2_CWS    = 0;
    localparam int          CC_FAST   = 0;
    localparam int          CC_MAIN   = 1;
    localparam int          CC_PLL    = 2;
    localparam int          CC_SEL    = 4;
    localparam int          CC_W      = 6;
    localparam logic [5:0]  CCTL_RST  = 6'h00;
    localparam logic [8:0]  IMSK_RST  = 9'h000;
    localparam logic [1:0]  SEL_SLOW  = 2'h0;

endpackage : rsc_pkg

`default_nettype wire

// ===== hdl/rsc_sync.sv
// two-flop synchroniser with rising-edge detect for reset source levels
`default_nettype none

module rsc_sync
    import rsc_pkg::*;
#(
    parameter int W = 9
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q,
    output logic      [W-1:0] rise
);

    logic [W-1:0] meta;
    logic [W-1:0] prev;

    // meta feeds only q; edge logic looks at q and prev
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            q    <= '0;
            prev <= '0;
        end else if (ce) begin
            meta <= d;
            q    <= meta;
            prev <= q;
        end
    end

    // one event per assertion, however long the source holds
    assign rise = q & ~prev;

endmodule : rsc_sync

`default_nettype wire

// ===== test/test_reset_scope_controller.sv
// self-checking bench for the reset scope controller
`default_nettype none

module test_reset_scope_controller
    import rsc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // expectation tables, bit order pin por mon0 independent_watchdog wdt mon1 mon2 deep sw
    // ----------------------------------------
    localparam logic [31:0] VEC_VAL = 32'h0000_2A40;
    localparam logic [8:0]  TGT_EXP [9] = '{9'h087, 9'h08F, 9'h01F, 9'h09F, 9'h03F, 9'h0BF, 9'h000, 9'h17F, 9'h1FF};
    localparam logic [8:0]  FLG_EXP [9] = '{9'h000, 9'h001, 9'h003, 9'h087, 9'h08F, 9'h01F, 9'h03F, 9'h07F, 9'h0FF};
    localparam logic [7:0]  BAD_ADDR [3] = '{8'h1C, 8'h02, 8'h40};

    logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [AW-1:0]   paddr;
    logic [31:0]     pwdata, prdata, rd;
    logic            er, fosc, mosc, pll, slow_sel, cws, ce;
    logic [1:0]      sel;
    logic [8:0]      src, cap, flg, ist, imsk;
    logic [5:0]      cctl;
    wire  [8:0]      clrs;
    int              fail_count, n_checks;

    rsc_ctrl #(.RESET_VECTOR(VEC_VAL)) DUT (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .src_pin_n(~src[S_PIN]), .src_por(src[S_POR]), .src_mon0(src[S_MON0]), .src_independent_watchdog(src[S_INDEPENDENT_WATCHDOG]),
        .src_wdt(src[S_WDT]), .src_mon1(src[S_MON1]), .src_mon2(src[S_MON2]), .src_deep(src[S_DEEP]),
        .src_sw(src[S_SW]), .clr_independent_watchdog(clrs[T_INDEPENDENT_WATCHDOG]), .clr_wdt(clrs[T_WDT]), .clr_mon1(clrs[T_MON1]),
        .clr_mon1_part(clrs[T_MON1P]), .clr_mon2(clrs[T_MON2]), .clr_mon2_part(clrs[T_MON2P]),
        .clr_rtc(clrs[T_RTC]), .clr_osc_pin_lp(clrs[T_OSC]), .clr_rest(clrs[T_REST]),
        .fast_internal_osc_en(fosc), .main_osc_en(mosc), .pll_en(pll), .sys_clk_sel(sel),
        .slow_internal_osc_sel(slow_sel), .irq(irq)
    );

    // clock, and a sticky record of every clear pulse since the last wipe
    initial pclk = 1'b0;
    always #25 pclk = ~pclk;
    always @(posedge pclk) cap = cap | clrs;

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task complete_run();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run

    // ----------------------------------------
    // apb master: setup, then access held until pready at an edge
    // ----------------------------------------
    task apb(input logic is_wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= is_wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // no cycle limit here: only the bench watchdog ends a stuck access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
        chk("write error", er, 0);
    endtask : wr

    task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, rd, exp);
    endtask : rd_chk

    // expected clear outputs for a set of simultaneous sources
    function automatic logic [8:0] exp_clears(input logic [8:0] set);
        logic [8:0] r;
        for (int t = 0; t < NTGT; t++) r[t] = |(TGT_EXP[t] & set);
        return r;
    endfunction : exp_clears

    // model update: clears first, own flag set afterwards so it wins
    task apply(input logic [8:0] set);
        for (int f = 1; f < NSRC; f++) if (|(FLG_EXP[f] & set)) flg[f] = 1'b0;
        flg  = flg | (set & 9'h1FE);
        cws  = set[S_POR] ? 1'b0 : cws;
        ist  = ist | set;
        cctl = 6'h00;
    endtask : apply

    task chk_regs();
        rd_chk("stat0", OFS_STAT0, {27'h0, flg[S_DEEP], flg[S_MON2], flg[S_MON1], flg[S_MON0], flg[S_POR]});
        rd_chk("stat1", OFS_STAT1, {29'h0, flg[S_INDEPENDENT_WATCHDOG], flg[S_WDT], flg[S_SW]});
        rd_chk("stat2", OFS_STAT2, {31'h0, cws});
        rd_chk("ist", OFS_IST, {23'h0, ist});
        rd_chk("imsk", OFS_IMSK, {23'h0, imsk});
        rd_chk("cctl", OFS_CCTL, {26'h0, cctl});
        @(negedge pclk);
        chk("clock outputs", {fosc, mosc, pll, sel, slow_sel}, {cctl[0], cctl[1], cctl[2], cctl[5:4], cctl[5:4] == 2'h0});
        chk("irq", irq, |(ist & imsk));
    endtask : chk_regs

    // one reset event: random setup, fire sources together, check everything
    task round(input logic [8:0] set);
        logic [8:0] k;
        cctl = 6'($urandom) & 6'h37;
        cws  = 1'($urandom);
        imsk = 9'($urandom);
        wr(OFS_CCTL, {26'h0, cctl});
        wr(OFS_STAT2, {31'h0, cws});
        wr(OFS_IMSK, {23'h0, imsk});
        chk_regs();
        cap = 9'h000;
        @(posedge pclk);
        src <= set;
        // freeze the block for three edges mid-capture; the event must still land once
        @(posedge pclk);
        ce <= 1'b0;
        repeat (3) @(posedge pclk);
        ce <= 1'b1;
        repeat (4) @(posedge pclk);
        src <= 9'h000;
        repeat (6) @(posedge pclk);
        apply(set);
        @(negedge pclk);
        chk("clear pulses", cap, exp_clears(set));
        // gather the flags the block shows and demand every own source flag set
        apb(1'b0, OFS_STAT0, 32'h0000_0000);
        k = {1'b0, rd[B0_DEEP], rd[B0_MON2], rd[B0_MON1], 2'b00, rd[B0_MON0], rd[B0_POR], 1'b0};
        apb(1'b0, OFS_STAT1, 32'h0000_0000);
        k = k | {rd[B1_SW], 3'b000, rd[B1_WDT], rd[B1_INDEPENDENT_WATCHDOG], 3'b000};
        chk("own flags set", k & set, set & 9'h1FE);
        rd_chk("stat0", OFS_STAT0, {27'h0, flg[S_DEEP], flg[S_MON2], flg[S_MON1], flg[S_MON0], flg[S_POR]});
        rd_chk("stat1", OFS_STAT1, {29'h0, flg[S_INDEPENDENT_WATCHDOG], flg[S_WDT], flg[S_SW]});
        chk_regs();
        k = 9'($urandom);
        wr(OFS_IST, {23'h0, k});
        ist = ist & ~k;
        rd_chk("ist w1c", OFS_IST, {23'h0, ist});
        @(negedge pclk);
        chk("irq after w1c", irq, |(ist & imsk));
    endtask : round

    // watchdog, far beyond the few thousand cycles the tests need
    initial begin
        repeat (40000) @(posedge pclk);
        fail_count++;
        $display("ERROR watchdog expected finish seen timeout");
        complete_run();
    end

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [8:0] s;
        presetn = 1'b0;
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
        src     = 9'h000;
        ce      = 1'b1;
        cap     = 9'h000;
        flg     = 9'h000;
        ist     = 9'h000;
        imsk    = 9'h000;
        cctl    = 6'h00;
        cws     = 1'b0;
        fail_count = 0;
        n_checks   = 0;
        void'($urandom(32'hD8C2_B17E));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        chk("clears idle", clrs, 0);
        chk_regs();
        rd_chk("vector", OFS_VEC, VEC_VAL);
        $display("test reset values done");

        // read-only places ignore writes, unmapped places refuse
        apb(1'b1, OFS_STAT0, 32'hFFFF_FFFF);
        chk("ro write error", er, 0);
        apb(1'b1, OFS_VEC, 32'hFFFF_FFFF);
        chk("ro write error", er, 0);
        rd_chk("vector kept", OFS_VEC, VEC_VAL);
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, BAD_ADDR[i], 32'hFFFF_FFFF);
            chk("unmapped write error", er, 1);
            apb(1'b0, BAD_ADDR[i], 32'h0000_0000);
            chk("unmapped read error", er, 1);
            chk("unmapped read data", rd, 0);
        end
        chk_regs();
        $display("test register access done");

        // every source alone, then a repeat of the pin and software sources
        for (int i = 0; i < NSRC; i++) round(9'h001 << i);
        round(9'h001);
        round(9'h100);
        $display("test single sources done");

        // simultaneous sources: all nine, then random sets
        round(9'h1FF);
        repeat (12) begin
            s = 9'($urandom);
            round((s == 9'h000) ? 9'h180 : s);
        end
        $display("test combined sources done");
        complete_run();
    end

endmodule : test_reset_scope_controller

`default_nettype wire
